// *** include/sslb_pkg.sv ***
// What this block does
// R1 - Select bits 00 load the control latch
// R2 - Select bits 10 load the main divider latch
// R3 - Select bits 01 load the reference divider latch
// R4 - Shift data on serial clock, latch on strobe
// R5 - Host keeps serial clock at 20 MHz max
// R6 - Mute-until-lock keeps RF outputs off until locked
// R7 - Control bit 10 picks pump current setting
// R8 - Pump gain follows the latest of two writes
// R9 - Three-state bit floats the charge pump
// R10 - Polarity bit: one positive, zero negative
// R11 - Counter reset bit holds all counters
// R12 - Swallow count field is 5 bits, 0..31
// R13 - Host writes zero to main latch bit 7
// R14 - Main count field is 13 bits, 3..8191
// R15 - Feedback ratio is modulus times main plus swallow
// R16 - Main latch bit 22 enables output halving
// R17 - Main latch bit 23 feeds prescaler from halved output
// R18 - Reference divide field is 14 bits, 1..16383
// R19 - Reference bits 16 and 17 set antibacklash width
// R20 - Lock after five or three good cycles
// R21 - Test flag zero ignores the test latch
// R22 - Band clock divider divides reference counter output
// R23 - Host writes zero to reference bits 23, 22
// R24 - Host programs reference, control, then main latch
// R25 - Word shifted MSB first, select bits last
package sslb_pkg;

  localparam int unsigned WORD_W = 24;
  localparam logic [23:0] WORD_RESET = 24'h000000;

  // Latch select codes in bits 1:0 of the shifted word
  localparam logic [1:0] SEL_CONTROL = 2'h0;
  localparam logic [1:0] SEL_MAIN    = 2'h2;
  localparam logic [1:0] SEL_REF     = 2'h1;
  localparam logic [1:0] SEL_TEST    = 2'h3;

  // Control latch fields
  localparam int unsigned CTL_PRESC_LSB = 22;
  localparam int unsigned CTL_PWRDN_LSB = 20;
  localparam int unsigned CTL_CUR2_LSB  = 17;
  localparam int unsigned CTL_CUR1_LSB  = 14;
  localparam int unsigned CTL_RFPWR_LSB = 12;
  localparam int unsigned CTL_MUTE_BIT  = 11;
  localparam int unsigned CTL_CPG_BIT   = 10;
  localparam int unsigned CTL_TRI_BIT   = 9;
  localparam int unsigned CTL_POL_BIT   = 8;
  localparam int unsigned CTL_MUX_LSB   = 5;
  localparam int unsigned CTL_CRST_BIT  = 4;
  localparam int unsigned CTL_CORE_LSB  = 2;

  // Main divider latch fields
  localparam int unsigned MAIN_A_LSB      = 2;
  localparam int unsigned MAIN_A_W        = 5;
  localparam int unsigned MAIN_B_LSB      = 8;
  localparam int unsigned MAIN_B_W        = 13;
  localparam int unsigned MAIN_CPG_BIT    = 21;
  localparam int unsigned MAIN_OUTPUT_HALVING_BIT   = 22;
  localparam int unsigned MAIN_HALVED_PRESCALER_INPUT_BIT = 23;

  // Reference divider latch fields
  localparam int unsigned REF_R_LSB   = 2;
  localparam int unsigned REF_R_W     = 14;
  localparam int unsigned REF_ABP_LSB = 16;
  localparam int unsigned REF_LDP_BIT = 18;
  localparam int unsigned REF_TMB_BIT = 19;
  localparam int unsigned REF_BSC_LSB = 20;

  // Legal lower limits of the divide fields
  localparam logic [12:0] MAIN_B_MIN = 13'h0003;
  localparam logic [13:0] REF_R_MIN  = 14'h0001;

  // Prescaler modulus codes and values
  localparam logic [1:0] PRESC_8  = 2'h0;
  localparam logic [1:0] PRESC_16 = 2'h1;
  localparam logic [5:0] MOD_8    = 6'h08;
  localparam logic [5:0] MOD_16   = 6'h10;
  localparam logic [5:0] MOD_32   = 6'h20;
  localparam int unsigned RATIO_W = 18;

  // Band clock divider codes: divide by 1, 2, 4 or 8
  localparam logic [2:0] BAND_DIV1 = 3'h0;
  localparam logic [2:0] BAND_OUTPUT_HALVING = 3'h1;
  localparam logic [2:0] BAND_DIV4 = 3'h3;
  localparam logic [2:0] BAND_DIV8 = 3'h7;

  // Synchronised pin positions
  localparam int unsigned PIN_SCLK  = 0;
  localparam int unsigned PIN_SDATA = 1;
  localparam int unsigned PIN_LOAD  = 2;
  localparam int unsigned PIN_REF   = 3;
  localparam int unsigned PIN_FB    = 4;
  localparam int unsigned PIN_COUNT = 5;

  // Lock detection timing
  localparam int unsigned CLK_PERIOD_PS  = 4000;
  localparam int unsigned LOCK_WINDOW_PS = 15000;
  localparam int unsigned LOCK_WINDOW_CYC = LOCK_WINDOW_PS / CLK_PERIOD_PS;
  localparam logic [2:0]  LOCK_GOOD_FINE   = 3'h5;
  localparam logic [2:0]  LOCK_GOOD_COARSE = 3'h3;

endpackage

// *** verification/sslb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sslb_host_model (
  input  wire logic clk,
  output var logic  serial_clk,
  output var logic  serial_data,
  output var logic  load_strobe
);
  // Clock and strobe idle low between frames
  initial begin
    serial_clk  = 1'b0;
    serial_data = 1'b0;
    load_strobe = 1'b0;
  end

  // Step n edges, then just past the edge
  task automatic tick(input int unsigned n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Half period of 7 or more cycles keeps the serial clock slow enough
  task automatic send_word(input logic [23:0] w, input int unsigned half);
    for (int i = 23; i >= 0; i--) begin // MSB first, select bits last
      serial_data = w[i];
      tick(half);
      serial_clk = 1'b1;
      tick(half);
      serial_clk = 1'b0;
    end
    serial_data = ~w[0]; // No stale bit left on a released line
    tick(2);
    load_strobe = 1'b1;
    tick(6);
    load_strobe = 1'b0;
    tick(4);
  endtask
endmodule
`default_nettype wire

// *** verification/sslb_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module sslb_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        load_strobe,
  input wire logic [1:0]  prescaler_choice,
  input wire logic        pump_gain_choice,
  input wire logic        hold_counters,
  input wire logic [4:0]  swallow_count_field,
  input wire logic [12:0] main_count_field,
  input wire logic [17:0] feedback_ratio,
  input wire logic [13:0] ref_divide_field,
  input wire logic        divider_setting_valid,
  input wire logic        pfd_tick,
  input wire logic        locked,
  input wire logic        rf_output_enable
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic [17:0] ratio_exp;

  // Modulus 8, 16, else 32 from the prescaler code
  always_comb begin
    ratio_exp = 18'(main_count_field) * ((prescaler_choice == 2'h0) ? 18'h8 :
      (prescaler_choice == 2'h1) ? 18'h10 : 18'h20) + 18'(swallow_count_field);
  end

  property p_ratio;
    $stable(main_count_field) && $stable(swallow_count_field) && $stable(prescaler_choice)
      |-> feedback_ratio == ratio_exp;
  endproperty
  a_ratio: assert property (p_ratio) else $error("feedback ratio wrong");

  property p_valid;
    $stable(main_count_field) && $stable(ref_divide_field) |-> divider_setting_valid ==
      (main_count_field >= 13'h3 && ref_divide_field != 14'h0);
  endproperty
  a_valid: assert property (p_valid) else $error("setting valid wrong");

  // Latched fields move only in answer to a strobe
  property p_main_load;
    $changed(main_count_field) |-> $past(load_strobe, 3);
  endproperty
  a_main_load: assert property (p_main_load) else $error("main field moved");

  property p_ref_load;
    $changed(ref_divide_field) |-> $past(load_strobe, 3);
  endproperty
  a_ref_load: assert property (p_ref_load) else $error("ref field moved");

  property p_gain_load;
    $changed(pump_gain_choice) |-> $past(load_strobe, 3);
  endproperty
  a_gain_load: assert property (p_gain_load) else $error("gain moved");

  property p_lock_enable;
    locked |=> rf_output_enable;
  endproperty
  a_lock_enable: assert property (p_lock_enable) else $error("output muted in lock");

  property p_mute_fall;
    $fell(rf_output_enable) |-> !$past(locked);
  endproperty
  a_mute_fall: assert property (p_mute_fall) else $error("muted while locked");

  property p_hold;
    hold_counters [*2] |-> !locked && !pfd_tick;
  endproperty
  a_hold: assert property (p_hold) else $error("counting during hold");

  // Lock is declared only within four cycles after a reference tick
  property p_lock_rise;
    $rose(locked) |-> !hold_counters && ($past(pfd_tick) || $past(pfd_tick, 2) ||
      $past(pfd_tick, 3) || $past(pfd_tick, 4));
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock without tick");
endmodule

bind sslb_serial_latch_bank sslb_sva u_sva (
  .clk, .nrst, .load_strobe, .prescaler_choice, .pump_gain_choice, .hold_counters,
  .swallow_count_field, .main_count_field, .feedback_ratio, .ref_divide_field,
  .divider_setting_valid, .pfd_tick, .locked, .rf_output_enable
);
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  typedef logic [102:0] sslb_obs_t;
  logic        clk, nrst, ref_in, fb_in, serial_clk, serial_data, load_strobe;
  logic [1:0]  prescaler_choice, power_down_mode, rf_output_strength, core_bias_level;
  logic [2:0]  current_setting1, current_setting2, monitor_mux_choice;
  logic        pump_gain_choice, pump_three_state, detector_polarity, hold_counters;
  logic [4:0]  swallow_count_field;
  logic [12:0] main_count_field;
  logic [17:0] feedback_ratio;
  logic        output_halving, halved_prescaler_input, lock_count_choice;
  logic [13:0] ref_divide_field;
  logic [1:0]  antibacklash_width, band_clock_divider;
  logic        divider_setting_valid, pfd_tick, band_select_clk, locked, rf_output_enable;
  logic [23:0] factory_test_view;
  logic [23:0] ctl = '0, mn = '0, rf = '0;
  logic        gain = 1'b0;
  sslb_obs_t   obs;
  sslb_obs_t   q[$];
  int          err_total = 0;
  int          comparisons = 0;

  sslb_serial_latch_bank uut (
    .clk, .nrst, .serial_clk, .serial_data, .load_strobe, .ref_in, .fb_in,
    .prescaler_choice, .power_down_mode, .current_setting1, .current_setting2,
    .rf_output_strength, .monitor_mux_choice, .core_bias_level, .pump_gain_choice,
    .pump_three_state, .detector_polarity, .hold_counters, .swallow_count_field,
    .main_count_field, .feedback_ratio, .output_halving, .halved_prescaler_input,
    .ref_divide_field, .antibacklash_width, .lock_count_choice, .band_clock_divider,
    .divider_setting_valid, .pfd_tick, .band_select_clk, .locked, .rf_output_enable,
    .factory_test_view
  );
  sslb_host_model host (.clk, .serial_clk, .serial_data, .load_strobe);

  assign obs = {prescaler_choice, power_down_mode, current_setting2, current_setting1,
    rf_output_strength, monitor_mux_choice, core_bias_level, pump_gain_choice,
    pump_three_state, detector_polarity, hold_counters, swallow_count_field,
    main_count_field, feedback_ratio, output_halving, halved_prescaler_input,
    ref_divide_field, antibacklash_width, lock_count_choice, band_clock_divider,
    divider_setting_valid, factory_test_view};

  // Expected outputs from the three latch images; test latch stays hidden
  function automatic sslb_obs_t expv();
    logic [17:0] p;
    p = (ctl[23:22] == 2'h0) ? 18'h8 : (ctl[23:22] == 2'h1) ? 18'h10 : 18'h20;
    return {ctl[23:22], ctl[21:20], ctl[19:17], ctl[16:14], ctl[13:12], ctl[7:5],
      ctl[3:2], gain, ctl[9], ctl[8], ctl[4], mn[6:2], mn[20:8],
      p * 18'(mn[20:8]) + 18'(mn[6:2]), mn[22], mn[23], rf[15:2], rf[17:16], rf[18],
      rf[21:20], (mn[20:8] >= sslb_pkg::MAIN_B_MIN) && (rf[15:2] != 14'h0), 24'h0};
  endfunction

  task automatic chk(input string n, input sslb_obs_t e, input sslb_obs_t g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Note the expected image, then shift the word in
  task automatic wr(input logic [23:0] w, input int unsigned half);
    if (w[1:0] == 2'h0) {ctl, gain} = {w, w[10]};
    if (w[1:0] == 2'h2) {mn, gain} = {w, w[21]}; // Latest gain write wins
    if (w[1:0] == 2'h1) rf = w;
    q.push_back(expv());
    host.send_word(w, half);
  endtask

  // One reference edge, with or without a feedback edge behind it
  task automatic pulse(input logic fb);
    ref_in = 1'b1;
    host.tick(1);
    fb_in = fb;
    host.tick(5);
    ref_in = 1'b0;
    fb_in = 1'b0;
    host.tick(6);
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Each strobe is answered by the fields a fixed few cycles later
  initial begin
    forever begin
      @(posedge load_strobe);
      repeat (7) @(posedge clk);
      #1;
      if (q.size() == 0) chk("queue", '0, '1);
      else chk("fields", q.pop_front(), obs);
    end
  end

  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    final_report();
  end

  initial begin
    static logic [12:0] bt [4] = '{13'h3, 13'h1fff, 13'h2, 13'h4};
    static logic [4:0]  at [4] = '{5'h0, 5'h1f, 5'h1f, 5'h0};
    static logic [13:0] rt [4] = '{14'h1, 14'h3fff, 14'h1, 14'h0};
    logic [23:0]        w;
    nrst = 1'b0;
    ref_in = 1'b0;
    fb_in = 1'b0;
    void'($urandom(32'hc1740310));
    repeat (12) @(posedge clk);
    #1 nrst = 1'b1;
    host.tick(2);
    // Extremes in power-up order: reference, control, main
    for (int i = 0; i < 4; i++) begin
      wr({2'h0, 2'(i), 1'b0, i[0], 2'(i), rt[i], 2'h1}, 7);
      wr({2'(i), 11'h0, i[0], i[1], i[0], 6'h0, 2'h0}, 7);
      wr({i[1], i[0], ~i[0], bt[i], 1'b0, at[i], 2'h2}, 13);
    end
    // Random words on all select codes, reserved bits zero
    for (int i = 0; i < 16; i++) begin
      w = 24'($urandom());
      w[1:0] = 2'(i);
      if (w[1:0] == 2'h2) w[7] = 1'b0;
      if (w[1:0] == 2'h1) w[23:19] = {2'h0, w[21:20], 1'b0};
      wr(w, (i % 2 == 1) ? 13 : 7);
    end
    // Lock after three good pairs, muted until then
    wr({5'h0, 1'b0, 2'h0, 14'h1, 2'h1}, 7);
    wr(24'h000800, 7);
    chk("rf_enable", '0, 103'(rf_output_enable));
    repeat (2) pulse(1'b1);
    chk("locked", '0, 103'(locked));
    pulse(1'b1);
    chk("locked", 103'h1, 103'(locked));
    chk("rf_enable", 103'h1, 103'(rf_output_enable));
    pulse(1'b0);
    chk("locked", '0, 103'(locked));
    // Precise lock needs five pairs
    wr({5'h0, 1'b1, 2'h0, 14'h1, 2'h1}, 7);
    repeat (4) pulse(1'b1);
    chk("locked", '0, 103'(locked));
    pulse(1'b1);
    chk("locked", 103'h1, 103'(locked));
    chk("band_clk", 103'h1, 103'(band_select_clk));
    // Counter hold drops lock and keeps it away
    wr(24'h000810, 7);
    repeat (3) pulse(1'b1);
    chk("locked", '0, 103'(locked));
    chk("rf_enable", '0, 103'(rf_output_enable));
    if (q.size() != 0) chk("queue", '0, '1);
    final_report();
  end
endmodule
`default_nettype wire

// *** verilog/sslb_lock_detect.sv ***
`timescale 1ns/100ps
`default_nettype none
module sslb_lock_detect #(
  parameter int unsigned WINDOW_CYC = sslb_pkg::LOCK_WINDOW_CYC
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic clear,
  input  wire logic ref_tick,
  input  wire logic fb_tick,
  input  wire logic precise,
  output logic      locked
);

  if (WINDOW_CYC < 1 || WINDOW_CYC > 15) begin : g_check
    $error("sslb_lock_detect window must be 1 to 15 cycles");
  end

  typedef enum logic [1:0] {LD_IDLE, LD_WAIT_FB, LD_WAIT_REF} sslb_ld_state_e;

  sslb_ld_state_e state_reg, state_next;
  logic [3:0]     gap_reg, gap_next;
  logic [2:0]     good_reg, good_next;
  logic           locked_reg, locked_next;
  logic           good_ev;
  logic           bad_ev;
  logic [2:0]     need;

  // Pair each reference edge with a feedback edge inside the window
  always_comb begin
    state_next = state_reg;
    gap_next   = gap_reg;
    good_ev    = 1'b0;
    bad_ev     = 1'b0;
    unique case (state_reg)
      LD_IDLE: begin
        gap_next = 4'h1;
        if (ref_tick && fb_tick) begin
          good_ev = 1'b1;
        end else if (ref_tick) begin
          state_next = LD_WAIT_FB;
        end else if (fb_tick) begin
          state_next = LD_WAIT_REF;
        end
      end
      LD_WAIT_FB, LD_WAIT_REF: begin
        gap_next = gap_reg + 4'h1;
        if ((state_reg == LD_WAIT_FB && fb_tick) || (state_reg == LD_WAIT_REF && ref_tick)) begin
          good_ev    = 1'b1;
          state_next = LD_IDLE;
        end else if (ref_tick || fb_tick || gap_reg >= 4'(WINDOW_CYC)) begin
          bad_ev     = 1'b1;
          state_next = LD_IDLE;
        end
      end
    endcase
  end

  // Count consecutive good cycles; one bad cycle drops lock
  always_comb begin
    need        = precise ? sslb_pkg::LOCK_GOOD_FINE : sslb_pkg::LOCK_GOOD_COARSE; // [R20]
    good_next   = good_reg;
    locked_next = locked_reg;
    if (bad_ev) begin
      good_next   = 3'h0;
      locked_next = 1'b0;
    end else if (good_ev && !locked_reg) begin
      good_next   = good_reg + 3'h1;
      locked_next = (good_reg + 3'h1 >= need); // [R20]
    end
  end

  // Counter reset also clears lock history
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg  <= LD_IDLE;
      gap_reg    <= 4'h0;
      good_reg   <= 3'h0;
      locked_reg <= 1'b0;
    end else if (clear) begin
      state_reg  <= LD_IDLE;
      gap_reg    <= 4'h0;
      good_reg   <= 3'h0;
      locked_reg <= 1'b0;
    end else begin
      state_reg  <= state_next;
      gap_reg    <= gap_next;
      good_reg   <= good_next;
      locked_reg <= locked_next;
    end
  end

  assign locked = locked_reg;

endmodule
`default_nettype wire

// *** verilog/sslb_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module sslb_pin_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  if (W < 1) begin : g_check
    $error("sslb_pin_sync needs at least one pin");
  end

  // Two flops per pin, then a third only for edge detection
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [2:0] stage_reg;
    logic [2:0] stage_next;

    always_comb begin
      stage_next = {stage_reg[1:0], pin_in[i]};
    end

    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        stage_reg <= 3'h0;
      end else begin
        stage_reg <= stage_next;
      end
    end

    // First flop feeds only the second one
    assign level[i] = stage_reg[1];
    assign rise[i]  = stage_reg[1] & ~stage_reg[2];
  end

endmodule
`default_nettype wire

// *** verilog/sslb_serial_latch_bank.sv ***
`timescale 1ns/100ps
`default_nettype none
module sslb_serial_latch_bank (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        serial_clk,
  input  wire logic        serial_data,
  input  wire logic        load_strobe,
  input  wire logic        ref_in,
  input  wire logic        fb_in,
  output logic [1:0]       prescaler_choice,
  output logic [1:0]       power_down_mode,
  output logic [2:0]       current_setting1,
  output logic [2:0]       current_setting2,
  output logic [1:0]       rf_output_strength,
  output logic [2:0]       monitor_mux_choice,
  output logic [1:0]       core_bias_level,
  output logic             pump_gain_choice,
  output logic             pump_three_state,
  output logic             detector_polarity,
  output logic             hold_counters,
  output logic [4:0]       swallow_count_field,
  output logic [12:0]      main_count_field,
  output logic [17:0]      feedback_ratio,
  output logic             output_halving,
  output logic             halved_prescaler_input,
  output logic [13:0]      ref_divide_field,
  output logic [1:0]       antibacklash_width,
  output logic             lock_count_choice,
  output logic [1:0]       band_clock_divider,
  output logic             divider_setting_valid,
  output logic             pfd_tick,
  output logic             band_select_clk,
  output logic             locked,
  output logic             rf_output_enable,
  output logic [23:0]      factory_test_view
);

  localparam int unsigned W = sslb_pkg::WORD_W;

  logic [sslb_pkg::PIN_COUNT-1:0] pin_level;
  logic [sslb_pkg::PIN_COUNT-1:0] pin_rise;

  // Pins come from the host and the loop; all pass two flops
  sslb_pin_sync #(
    .W (sslb_pkg::PIN_COUNT)
  ) u_sync (
    .clk    (clk),
    .nrst   (nrst),
    .pin_in ({fb_in, ref_in, load_strobe, serial_data, serial_clk}),
    .level  (pin_level),
    .rise   (pin_rise)
  );

  logic sclk_rise;
  logic sdata;
  logic load_rise;
  logic ref_rise;
  logic fb_rise;

  assign sclk_rise = pin_rise[sslb_pkg::PIN_SCLK];
  assign sdata     = pin_level[sslb_pkg::PIN_SDATA];
  assign load_rise = pin_rise[sslb_pkg::PIN_LOAD];
  assign ref_rise  = pin_rise[sslb_pkg::PIN_REF];
  assign fb_rise   = pin_rise[sslb_pkg::PIN_FB];

  // Shift register and the four latches
  logic [W-1:0] shift_reg, shift_next;
  logic [W-1:0] control_word_reg, control_word_next;
  logic [W-1:0] main_divider_word_reg, main_divider_word_next;
  logic [W-1:0] reference_divider_word_reg, reference_divider_word_next;
  logic [W-1:0] test_word_reg, test_word_next;
  logic         pump_gain_reg, pump_gain_next;

  // Sampling at 250 MHz resolves a 20 MHz serial clock with margin
  always_comb begin
    shift_next                  = shift_reg;
    control_word_next           = control_word_reg;
    main_divider_word_next      = main_divider_word_reg;
    reference_divider_word_next = reference_divider_word_reg;
    test_word_next              = test_word_reg;
    pump_gain_next              = pump_gain_reg;
    if (sclk_rise) begin
      shift_next = {shift_reg[W-2:0], sdata}; // [R4] [R25]
    end
    if (load_rise) begin
      unique case (shift_reg[1:0]) // [R4]
        sslb_pkg::SEL_CONTROL: begin
          control_word_next = shift_reg; // [R1]
          pump_gain_next    = shift_reg[sslb_pkg::CTL_CPG_BIT]; // [R8]
        end
        sslb_pkg::SEL_MAIN: begin
          main_divider_word_next = shift_reg; // [R2]
          pump_gain_next         = shift_reg[sslb_pkg::MAIN_CPG_BIT]; // [R8]
        end
        sslb_pkg::SEL_REF: begin
          reference_divider_word_next = shift_reg; // [R3]
        end
        sslb_pkg::SEL_TEST: begin
          test_word_next = shift_reg;
        end
      endcase
    end
  end

  // Latch contents are zero after reset so outputs are defined
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_reg                  <= sslb_pkg::WORD_RESET;
      control_word_reg           <= sslb_pkg::WORD_RESET;
      main_divider_word_reg      <= sslb_pkg::WORD_RESET;
      reference_divider_word_reg <= sslb_pkg::WORD_RESET;
      test_word_reg              <= sslb_pkg::WORD_RESET;
      pump_gain_reg              <= 1'b0;
    end else begin
      shift_reg                  <= shift_next;
      control_word_reg           <= control_word_next;
      main_divider_word_reg      <= main_divider_word_next;
      reference_divider_word_reg <= reference_divider_word_next;
      test_word_reg              <= test_word_next;
      pump_gain_reg              <= pump_gain_next;
    end
  end

  // Control latch fields, straight from the latch flops; pump gain from its own flop, also loaded by main writes
  assign prescaler_choice   = control_word_reg[sslb_pkg::CTL_PRESC_LSB +: 2];
  assign power_down_mode    = control_word_reg[sslb_pkg::CTL_PWRDN_LSB +: 2];
  assign current_setting1   = control_word_reg[sslb_pkg::CTL_CUR1_LSB +: 3];
  assign current_setting2   = control_word_reg[sslb_pkg::CTL_CUR2_LSB +: 3];
  assign rf_output_strength = control_word_reg[sslb_pkg::CTL_RFPWR_LSB +: 2];
  assign monitor_mux_choice = control_word_reg[sslb_pkg::CTL_MUX_LSB +: 3];
  assign core_bias_level    = control_word_reg[sslb_pkg::CTL_CORE_LSB +: 2];
  assign pump_gain_choice   = pump_gain_reg; // [R7] [R8]
  assign pump_three_state   = control_word_reg[sslb_pkg::CTL_TRI_BIT]; // [R9]
  assign detector_polarity  = control_word_reg[sslb_pkg::CTL_POL_BIT]; // [R10]
  assign hold_counters      = control_word_reg[sslb_pkg::CTL_CRST_BIT]; // [R11]

  // Main divider latch fields; reserved bit 7 is not used
  assign swallow_count_field    = main_divider_word_reg[sslb_pkg::MAIN_A_LSB +: sslb_pkg::MAIN_A_W]; // [R12]
  assign main_count_field       = main_divider_word_reg[sslb_pkg::MAIN_B_LSB +: sslb_pkg::MAIN_B_W]; // [R14]
  assign output_halving         = main_divider_word_reg[sslb_pkg::MAIN_OUTPUT_HALVING_BIT]; // [R16]
  assign halved_prescaler_input = main_divider_word_reg[sslb_pkg::MAIN_HALVED_PRESCALER_INPUT_BIT]; // [R17]

  // Reference latch fields; bits 23 and 22 are not used
  assign ref_divide_field   = reference_divider_word_reg[sslb_pkg::REF_R_LSB +: sslb_pkg::REF_R_W]; // [R18]
  assign antibacklash_width = reference_divider_word_reg[sslb_pkg::REF_ABP_LSB +: 2]; // [R19]
  assign lock_count_choice  = reference_divider_word_reg[sslb_pkg::REF_LDP_BIT];
  assign band_clock_divider = reference_divider_word_reg[sslb_pkg::REF_BSC_LSB +: 2];

  // Feedback ratio and field legality, one cycle behind the latches
  logic [5:0]                     presc_mod;
  logic [18:0]                    ratio_prod;
  logic [sslb_pkg::RATIO_W-1:0]   ratio_reg, ratio_next;
  logic                           valid_reg, valid_next;
  logic [W-1:0]                   test_view_reg, test_view_next;

  always_comb begin
    unique case (prescaler_choice)
      sslb_pkg::PRESC_8:  presc_mod = sslb_pkg::MOD_8;
      sslb_pkg::PRESC_16: presc_mod = sslb_pkg::MOD_16;
      default:            presc_mod = sslb_pkg::MOD_32;
    endcase
    ratio_prod = presc_mod * main_count_field; // [R15]
    ratio_next = ratio_prod[sslb_pkg::RATIO_W-1:0] + {13'h0000, swallow_count_field}; // [R15]
    valid_next = (main_count_field >= sslb_pkg::MAIN_B_MIN)
               && (ref_divide_field >= sslb_pkg::REF_R_MIN); // [R14] [R18]
    // Test contents only reach the outside with the test flag set
    test_view_next = reference_divider_word_reg[sslb_pkg::REF_TMB_BIT]
                   ? test_word_reg : sslb_pkg::WORD_RESET; // [R21]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ratio_reg     <= '0;
      valid_reg     <= 1'b0;
      test_view_reg <= sslb_pkg::WORD_RESET;
    end else begin
      ratio_reg     <= ratio_next;
      valid_reg     <= valid_next;
      test_view_reg <= test_view_next;
    end
  end

  assign feedback_ratio        = ratio_reg;
  assign divider_setting_valid = valid_reg;
  assign factory_test_view     = test_view_reg;

  // Reference counter and band select clock divider
  logic [13:0] ref_cnt_reg, ref_cnt_next;
  logic        pfd_reg, pfd_next;
  logic [2:0]  band_cnt_reg, band_cnt_next;
  logic [2:0]  band_top;
  logic        band_clk_reg, band_clk_next;

  // A zero divide ratio behaves as one rather than stalling
  always_comb begin
    ref_cnt_next  = ref_cnt_reg;
    pfd_next      = 1'b0;
    band_cnt_next = band_cnt_reg;
    band_clk_next = band_clk_reg;
    unique case (band_clock_divider)
      2'h0:    band_top = sslb_pkg::BAND_DIV1;
      2'h1:    band_top = sslb_pkg::BAND_OUTPUT_HALVING;
      2'h2:    band_top = sslb_pkg::BAND_DIV4;
      default: band_top = sslb_pkg::BAND_DIV8;
    endcase
    if (hold_counters) begin
      ref_cnt_next  = 14'h0000; // [R11]
      band_cnt_next = 3'h0; // [R11]
    end else begin
      if (ref_rise) begin
        if ({1'b0, ref_cnt_reg} + 15'h0001 >= {1'b0, ref_divide_field}) begin
          ref_cnt_next = 14'h0000;
          pfd_next     = 1'b1;
        end else begin
          ref_cnt_next = ref_cnt_reg + 14'h0001;
        end
      end
      if (pfd_reg) begin
        if (band_cnt_reg >= band_top) begin
          band_cnt_next = 3'h0;
          band_clk_next = ~band_clk_reg; // [R22]
        end else begin
          band_cnt_next = band_cnt_reg + 3'h1; // [R22]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ref_cnt_reg  <= 14'h0000;
      pfd_reg      <= 1'b0;
      band_cnt_reg <= 3'h0;
      band_clk_reg <= 1'b0;
    end else begin
      ref_cnt_reg  <= ref_cnt_next;
      pfd_reg      <= pfd_next;
      band_cnt_reg <= band_cnt_next;
      band_clk_reg <= band_clk_next;
    end
  end

  assign pfd_tick        = pfd_reg;
  assign band_select_clk = band_clk_reg;

  // Lock detection compares divided reference with the synchronised feedback pin edge
  logic lock_level;

  sslb_lock_detect #(
    .WINDOW_CYC (sslb_pkg::LOCK_WINDOW_CYC)
  ) u_lock (
    .clk      (clk),
    .nrst     (nrst),
    .clear    (hold_counters), // [R11]
    .ref_tick (pfd_reg),
    .fb_tick  (fb_rise),
    .precise  (lock_count_choice), // [R20]
    .locked   (lock_level)
  );

  // Output gating follows lock one cycle later when muting is on
  logic rf_en_reg, rf_en_next;

  always_comb begin
    rf_en_next = ~(control_word_reg[sslb_pkg::CTL_MUTE_BIT] & ~lock_level); // [R6]
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rf_en_reg <= 1'b0;
    end else begin
      rf_en_reg <= rf_en_next;
    end
  end

  assign rf_output_enable = rf_en_reg;
  assign locked           = lock_level;

endmodule
`default_nettype wire
